// File: trcoc_bench.sv
`timescale 1ns/1ps
`include "trcoc_consts.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module trcoc_bench import trcoc_pkg::*;;
   logic clock_in = 0, rstn_in = 0, soft_reset_in = 0, addr_rewind_in = 0, write_all_in = 0;
   logic [`TRCOC_WORD_W-1:0] word_data_in = '0;
   logic write_ready_out, word_addr_strobe_out, reconfig_done_out, busy_out, rx_isolate_out;
   logic [`TRCOC_FROMGX_W-1:0] from_channel_in;
   trcoc_togx_t to_channel_out;
   logic [`TRCOC_ADDR_W-1:0] word_addr_out;
   int n_mismatch = 0, compares = 0;
   initial forever #2.5 clock_in = ~clock_in;
   trcoc_top i_trcoc_top (.clock_in, .rstn_in, .soft_reset_in, .addr_rewind_in, .word_data_in,
      .write_all_in, .write_ready_out, .from_channel_in, .to_channel_out, .word_addr_out,
      .word_addr_strobe_out, .reconfig_done_out, .busy_out, .rx_isolate_out);
   trcoc_chan_model i_trcoc_chan_model (.clock_in, .to_channel_in(to_channel_out),
      .from_channel_out(from_channel_in));
   task automatic cyc(int n);
      repeat (n) @(posedge clock_in);
   endtask
   task automatic power_up(logic sr);
      @(posedge clock_in);
      rstn_in <= 1'b0;
      soft_reset_in <= sr;
      cyc(3);
      rstn_in <= 1'b1;
   endtask
   task automatic oc_run(int exp);
      int n, m;
      n = 0;
      m = 0;
      repeat (40) begin
         @(posedge clock_in);
         if (busy_out === 1'b1) n++;
         if (rx_isolate_out === 1'b1) m++;
      end
      `CHK(n, exp)
      `CHK(m, exp)
   endtask
   // holds the strobe across back-to-back words, each taken on an edge with ready high
   task automatic burst(int n);
      int k, n0;
      k = 0;
      n0 = i_trcoc_chan_model.n_words;
      write_all_in <= 1'b1;
      for (int i = 0; i < n; i++) begin
         word_data_in <= 16'(16'hc300 + i);
         do @(posedge clock_in); while (write_ready_out !== 1'b1 && ++k < 300);
      end
      write_all_in <= 1'b0;
      cyc(4);
      `CHK(i_trcoc_chan_model.n_words - n0, n)
      `CHK(i_trcoc_chan_model.last_word.data, 16'(16'hc300 + n - 1))
   endtask
   task automatic s_words();
      burst(64);
      `CHK(reconfig_done_out, 1'b1)
      `CHK(word_addr_out, 6'h00)
      `CHK(i_trcoc_chan_model.last_word.addr, `TRCOC_LAST_ADDR)
      burst(1);
      `CHK(reconfig_done_out, 1'b0)
      `CHK(word_addr_out, 6'h01)
   endtask
   task automatic s_rewind();
      burst(3);
      addr_rewind_in <= 1'b1;
      @(posedge clock_in);
      addr_rewind_in <= 1'b0;
      cyc(3);
      `CHK(word_addr_out, 6'h00)
      burst(1);
      `CHK(i_trcoc_chan_model.last_word.addr, 6'h00)
   endtask
   task automatic s_soft(int hold, int exp);
      soft_reset_in <= 1'b1;
      cyc(hold);
      `CHK(busy_out, 1'b0)
      `CHK(reconfig_done_out, 1'b0)
      soft_reset_in <= 1'b0;
      oc_run(exp);
   endtask
   task automatic final_report();
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #30us;
      n_mismatch++;
      final_report();
   end
   initial begin
      power_up(1'b0);
      cyc(1);
      `CHK(busy_out, 1'b0)
      oc_run(`TRCOC_OC_CYCLES);
      s_words();
      s_rewind();
      s_soft(3, 0);
      power_up(1'b1);
      cyc(6);
      `CHK(busy_out, 1'b0)
      s_soft(1, `TRCOC_OC_CYCLES);
      power_up(1'b0);
      cyc(6);
      s_soft(2, `TRCOC_OC_CYCLES);
      final_report();
   end
endmodule

// File: trcoc_chan_model.sv
`timescale 1ns/1ps
`include "trcoc_consts.svh"
module trcoc_chan_model import trcoc_pkg::*; (
   input wire logic clock_in,
   input wire trcoc_togx_t to_channel_in,
   output logic [`TRCOC_FROMGX_W-1:0] from_channel_out
);
   int n_words = 0;
   trcoc_togx_t last_word = '0;
   // the channel is never powered down, so only the bench's resets interrupt a cancellation
   initial from_channel_out = 5'h0a;
   // status bus toggles every cycle so no stale value is mistaken for a real one
   always @(posedge clock_in) begin
      from_channel_out <= ~from_channel_out;
      if (to_channel_in.cmd == `TRCOC_CMD_WRITE) begin
         n_words <= n_words + 1;
         last_word <= to_channel_in;
      end
   end
endmodule

// File: trcoc_consts.svh
`ifndef TRCOC_CONSTS_SVH
`define TRCOC_CONSTS_SVH
`define TRCOC_WORD_W 16
`define TRCOC_ADDR_W 6
`define TRCOC_LAST_ADDR 6'h3f
`define TRCOC_FIFO_DEPTH 16
`define TRCOC_CLK_PERIOD_NS 5
`define TRCOC_OC_TIME_NS 80
`define TRCOC_OC_CYCLES (`TRCOC_OC_TIME_NS / `TRCOC_CLK_PERIOD_NS)
`define TRCOC_TOGX_W 4
`define TRCOC_FROMGX_W 5
`define TRCOC_CMD_IDLE 4'h0
`define TRCOC_CMD_ISOLATE 4'h1
`define TRCOC_CMD_CANCEL 4'h2
`define TRCOC_CMD_WRITE 4'h4
`define TRCOC_CMD_RELEASE 4'h8
`endif

// File: trcoc_fifo.sv
`timescale 1ns/1ps
module trcoc_fifo #(
   parameter int WIDTH = 22,
   parameter int DEPTH = 16
) (
   input wire logic clock_in,
   input wire logic clear_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   output logic [WIDTH-1:0] rd_data_out,
   output logic rd_valid_out,
   input wire logic rd_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic do_wr;
   logic do_rd;
   assign wr_ready_out = (count_reg != (AW+1)'(DEPTH));
   assign rd_valid_out = (count_reg != '0);
   assign rd_data_out = mem_reg[rd_ptr_reg];
   assign do_wr = wr_valid_in && wr_ready_out;
   assign do_rd = rd_valid_out && rd_ready_in;
   always_ff @(posedge clock_in) begin
      if (do_wr) begin
         mem_reg[wr_ptr_reg] <= wr_data_in;
      end
   end
   always_ff @(posedge clock_in) begin
      if (clear_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         if (do_wr && !do_rd) begin
            count_reg <= count_reg + 1'b1;
         end else if (do_rd && !do_wr) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule

// File: trcoc_pkg.sv
`include "trcoc_consts.svh"
package trcoc_pkg;
   typedef enum {TRCOC_ST_POWERUP, TRCOC_ST_ISOLATE, TRCOC_ST_CANCEL, TRCOC_ST_BUFFER,
      TRCOC_ST_IDLE} trcoc_state_t;
   typedef struct packed {
      logic [`TRCOC_WORD_W-1:0] data;
      logic [`TRCOC_ADDR_W-1:0] addr;
   } trcoc_word_t;
   typedef struct packed {
      logic [`TRCOC_TOGX_W-1:0] cmd;
      logic [`TRCOC_WORD_W-1:0] data;
      logic [`TRCOC_ADDR_W-1:0] addr;
   } trcoc_togx_t;
endpackage

// File: trcoc_top.sv
`timescale 1ns/1ps
`include "trcoc_consts.svh"
module trcoc_top import trcoc_pkg::*; #(
   parameter bit RX_PRESENT = 1'b1
) (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic soft_reset_in,
   input wire logic addr_rewind_in,
   input wire logic [`TRCOC_WORD_W-1:0] word_data_in,
   input wire logic write_all_in,
   output logic write_ready_out,
   input wire logic [`TRCOC_FROMGX_W-1:0] from_channel_in,
   output trcoc_togx_t to_channel_out,
   output logic [`TRCOC_ADDR_W-1:0] word_addr_out,
   output logic word_addr_strobe_out,
   output logic reconfig_done_out,
   output logic busy_out,
   output logic rx_isolate_out
);
   localparam int OC_CYC = (`TRCOC_OC_CYCLES < 1) ? 1 : `TRCOC_OC_CYCLES;
   trcoc_state_t state_reg;
   trcoc_state_t state_next;
   logic [4:0] oc_cnt_reg;
   logic oc_done_reg;
   logic [`TRCOC_ADDR_W-1:0] index_reg;
   logic clr;
   trcoc_word_t fifo_in;
   trcoc_word_t fifo_out;
   logic fifo_valid;
   logic fifo_ready;
   logic wr_ok;
   logic [`TRCOC_ADDR_W-1:0] index_adv;
   logic take;

   function automatic logic [`TRCOC_ADDR_W-1:0] next_index(
      input logic [`TRCOC_ADDR_W-1:0] idx);
      next_index = (idx == `TRCOC_LAST_ADDR) ? '0 : idx + 1'b1;
   endfunction

   assign clr = !rstn_in || soft_reset_in;
   assign index_adv = next_index(index_reg);
   assign fifo_in.data = word_data_in;
   assign fifo_in.addr = addr_rewind_in ? '0 : index_adv;
   // words are only written once cancellation is over
   assign wr_ok = (state_reg == TRCOC_ST_IDLE);
   // a word is taken only while ready is shown, so the user never loses or repeats one
   assign take = write_all_in && write_ready_out && fifo_ready;

   trcoc_fifo #(
      .WIDTH($bits(trcoc_word_t)),
      .DEPTH(`TRCOC_FIFO_DEPTH)
   ) u_fifo (
      .clock_in(clock_in),
      .clear_in(clr),
      .wr_data_in(fifo_in),
      .wr_valid_in(take),
      .wr_ready_out(fifo_ready),
      .rd_data_out(fifo_out),
      .rd_valid_out(fifo_valid),
      .rd_ready_in(wr_ok)
   );

   // cancellation state walk; soft reset restarts it unless already done
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         TRCOC_ST_POWERUP: begin
            state_next = RX_PRESENT ? TRCOC_ST_ISOLATE : TRCOC_ST_IDLE;
         end
         TRCOC_ST_ISOLATE: begin
            state_next = TRCOC_ST_CANCEL;
         end
         TRCOC_ST_CANCEL: begin
            if (oc_cnt_reg == 5'(OC_CYC - 3)) begin
               state_next = TRCOC_ST_BUFFER;
            end
         end
         TRCOC_ST_BUFFER: begin
            state_next = TRCOC_ST_IDLE;
         end
         TRCOC_ST_IDLE: begin
            state_next = TRCOC_ST_IDLE;
         end
         default: begin
            state_next = TRCOC_ST_POWERUP;
         end
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         state_reg <= TRCOC_ST_POWERUP;
         oc_done_reg <= 1'b0;
      end else if (soft_reset_in) begin
         state_reg <= oc_done_reg ? TRCOC_ST_IDLE : TRCOC_ST_POWERUP;
      end else begin
         state_reg <= state_next;
         if (state_reg == TRCOC_ST_BUFFER) begin
            oc_done_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (clr || state_reg != TRCOC_ST_CANCEL) begin
         oc_cnt_reg <= '0;
      end else begin
         oc_cnt_reg <= oc_cnt_reg + 1'b1;
      end
   end

   // busy covers OC_CYC cycles from the second cycle on
   always_ff @(posedge clock_in) begin
      if (clr) begin
         busy_out <= 1'b0;
         rx_isolate_out <= 1'b0;
      end else begin
         busy_out <= (state_next != TRCOC_ST_IDLE) && (state_next != TRCOC_ST_POWERUP);
         rx_isolate_out <= (state_next == TRCOC_ST_ISOLATE) ||
            (state_next == TRCOC_ST_CANCEL) || (state_next == TRCOC_ST_BUFFER);
      end
   end

   // index and write path
   always_ff @(posedge clock_in) begin
      if (clr) begin
         index_reg <= `TRCOC_LAST_ADDR;
      end else if (addr_rewind_in) begin
         // a word taken with the rewind already used address zero
         index_reg <= take ? '0 : `TRCOC_LAST_ADDR;
      end else if (take) begin
         index_reg <= index_adv;
      end
   end

   always_ff @(posedge clock_in) begin
      if (clr) begin
         to_channel_out <= '0;
         word_addr_out <= '0;
         word_addr_strobe_out <= 1'b0;
         reconfig_done_out <= 1'b0;
         write_ready_out <= 1'b0;
      end else begin
         write_ready_out <= fifo_ready && (state_next == TRCOC_ST_IDLE);
         to_channel_out.cmd <= (state_reg == TRCOC_ST_ISOLATE) ? `TRCOC_CMD_ISOLATE :
            (state_reg == TRCOC_ST_CANCEL) ? `TRCOC_CMD_CANCEL :
            (state_reg == TRCOC_ST_BUFFER) ? `TRCOC_CMD_RELEASE :
            (fifo_valid && wr_ok) ? `TRCOC_CMD_WRITE : `TRCOC_CMD_IDLE;
         to_channel_out.data <= fifo_out.data;
         to_channel_out.addr <= fifo_out.addr;
         word_addr_strobe_out <= 1'b0;
         if (fifo_valid && wr_ok) begin
            word_addr_out <= next_index(fifo_out.addr);
            word_addr_strobe_out <= 1'b1;
            if (fifo_out.addr == '0) begin
               reconfig_done_out <= 1'b0;
            end
            if (fifo_out.addr == `TRCOC_LAST_ADDR) begin
               reconfig_done_out <= 1'b1;
            end
         end else if (addr_rewind_in) begin
            word_addr_out <= '0;
         end
      end
   end
endmodule

// File: trcoc_top_chk.sv
`timescale 1ns/1ps
`include "trcoc_consts.svh"
module trcoc_top_chk import trcoc_pkg::*; (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic soft_reset_in,
   input wire logic addr_rewind_in,
   input wire logic write_ready_out,
   input wire trcoc_togx_t to_channel_out,
   input wire logic [`TRCOC_ADDR_W-1:0] word_addr_out,
   input wire logic word_addr_strobe_out,
   input wire logic reconfig_done_out,
   input wire logic busy_out,
   input wire logic rx_isolate_out
);
   localparam int OC = `TRCOC_OC_CYCLES;
   int busy_cnt;
   logic oc_seen;
   default clocking @(posedge clock_in); endclocking
   always_ff @(posedge clock_in) begin
      if (!rstn_in || soft_reset_in) busy_cnt <= 0;
      else if (busy_out) busy_cnt <= busy_cnt + 1;
      else busy_cnt <= 0;
   end
   // set once a full cancellation has run to its end
   always_ff @(posedge clock_in) begin
      if (!rstn_in) oc_seen <= 1'b0;
      else if (!busy_out && busy_cnt == OC) oc_seen <= 1'b1;
   end
   a_busy_start: assert property (disable iff (!rstn_in || soft_reset_in)
      $rose(rstn_in) |-> !busy_out ##[1:2] busy_out) else $error("busy start wrong");
   a_busy_len: assert property (disable iff (!rstn_in || soft_reset_in)
      !busy_out && $past(busy_out) && !$past(soft_reset_in) |-> busy_cnt == OC)
      else $error("busy length wrong");
   a_ready_busy: assert property (disable iff (!rstn_in)
      busy_out |-> !write_ready_out) else $error("ready while busy");
   a_strobe_cmd: assert property (disable iff (!rstn_in)
      word_addr_strobe_out |-> to_channel_out.cmd == `TRCOC_CMD_WRITE)
      else $error("strobe without write");
   a_addr_step: assert property (disable iff (!rstn_in)
      word_addr_strobe_out |-> word_addr_out == `TRCOC_ADDR_W'(to_channel_out.addr + 1))
      else $error("index step wrong");
   a_done_last: assert property (disable iff (!rstn_in || soft_reset_in)
      word_addr_strobe_out && to_channel_out.addr == `TRCOC_LAST_ADDR |-> ##[0:1]
      reconfig_done_out) else $error("done missing");
   a_rewind_zero: assert property (disable iff (!rstn_in || soft_reset_in)
      addr_rewind_in |-> ##[1:2] word_addr_out == '0) else $error("rewind failed");
   a_soft_clear: assert property (disable iff (!rstn_in)
      soft_reset_in |=> !busy_out && !reconfig_done_out) else $error("soft reset no clear");
   a_run_once: assert property (disable iff (!rstn_in)
      oc_seen |-> !busy_out) else $error("cancellation rerun");
   a_iso_start: assert property (disable iff (!rstn_in || soft_reset_in)
      $rose(busy_out) |=> to_channel_out.cmd == `TRCOC_CMD_ISOLATE)
      else $error("isolate step missing");
   a_iso_level: assert property (disable iff (!rstn_in)
      busy_out |-> rx_isolate_out) else $error("pins not isolated");
   a_release_end: assert property (disable iff (!rstn_in || soft_reset_in)
      $fell(busy_out) && !$past(soft_reset_in) |-> to_channel_out.cmd == `TRCOC_CMD_RELEASE)
      else $error("buffer step missing");
endmodule
bind trcoc_top trcoc_top_chk i_trcoc_top_chk (.clock_in, .rstn_in, .soft_reset_in,
   .addr_rewind_in, .write_ready_out, .to_channel_out, .word_addr_out,
   .word_addr_strobe_out, .reconfig_done_out, .busy_out, .rx_isolate_out);
